// File: src/axil_reg_port.sv
// AXI4-Lite slave front end: holds address and data, one write and one read at a time
// assumes the core decodes combinationally and answers the hit flags
module axil_reg_port (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic [15:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [15:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             wr_en_o,
  output logic [15:0]      wr_addr_o,
  output logic [31:0]      wr_data_o,
  output logic [3:0]       wr_strb_o,
  input  wire logic        wr_hit_i,
  input  wire logic [31:0] rd_data_i,
  input  wire logic        rd_hit_i
);
  logic        aw_full_q, aw_full_d, w_full_q, w_full_d;
  logic [15:0] aw_addr_q, aw_addr_d;
  logic [31:0] w_data_q, w_data_d, rdata_q, rdata_d;
  logic [3:0]  w_strb_q, w_strb_d;
  logic        bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
  logic        awrdy_q, awrdy_d, wrdy_q, wrdy_d, arrdy_q, arrdy_d;

  // =====================================================================
  // write path: address and data in either order, then one response
  always_comb begin
    aw_full_d = aw_full_q;
    aw_addr_d = aw_addr_q;
    w_full_d  = w_full_q;
    w_data_d  = w_data_q;
    w_strb_d  = w_strb_q;
    bvalid_d  = bvalid_q && !s_axi_bready;
    bresp_d   = bresp_q;
    wr_en_o   = aw_full_q && w_full_q && !bvalid_q;
    if (s_axi_awvalid && awrdy_q) begin
      aw_full_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wrdy_q) begin
      w_full_d = 1'b1;
      w_data_d = s_axi_wdata;
      w_strb_d = s_axi_wstrb;
    end
    if (wr_en_o) begin
      aw_full_d = 1'b0;
      w_full_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = wr_hit_i ? store_seq_pkg::RESP_OKAY
                           : store_seq_pkg::RESP_SLVERR;
    end
    // readies are registered so the bus sees flop outputs
    awrdy_d = !aw_full_d && !bvalid_d && !wr_en_o;
    wrdy_d  = !w_full_d && !bvalid_d && !wr_en_o;
  end

  // read path: one cycle from address taken to data valid
  always_comb begin
    rvalid_d = rvalid_q && !s_axi_rready;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (s_axi_arvalid && arrdy_q) begin
      rvalid_d = 1'b1;
      rdata_d  = rd_hit_i ? rd_data_i : 32'h0000_0000;
      rresp_d  = rd_hit_i ? store_seq_pkg::RESP_OKAY
                          : store_seq_pkg::RESP_SLVERR;
    end
    arrdy_d = !rvalid_d;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= 16'h0000;
      w_full_q  <= 1'b0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= 2'h0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= 2'h0;
      awrdy_q   <= 1'b0;
      wrdy_q    <= 1'b0;
      arrdy_q   <= 1'b0;
    end else begin
      aw_full_q <= aw_full_d;
      aw_addr_q <= aw_addr_d;
      w_full_q  <= w_full_d;
      w_data_q  <= w_data_d;
      w_strb_q  <= w_strb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
      awrdy_q   <= awrdy_d;
      wrdy_q    <= wrdy_d;
      arrdy_q   <= arrdy_d;
    end
  end

  assign wr_addr_o     = aw_addr_q;
  assign wr_data_o     = w_data_q;
  assign wr_strb_o     = w_strb_q;
  assign s_axi_awready = awrdy_q;
  assign s_axi_wready  = wrdy_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arrdy_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
endmodule // axil_reg_port

// File: src/eeprom_store_sequencer.sv
// eeprom store sequencer: walks the storage table, streams bytes out
// assumes the register map answers a read one cycle after map_rd_o
//
// The AXI4-Lite slave port was decided locally.
module eeprom_store_sequencer (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic [15:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [15:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             map_rd_o,
  output logic [15:0]      map_addr_o,
  input  wire logic [7:0]  map_data_i,
  output logic             ee_valid_o,
  output logic [15:0]      ee_addr_o,
  output logic [7:0]       ee_data_o,
  input  wire logic        ee_ready_i
);
  localparam int TL = store_seq_pkg::TBL_LEN;

  store_seq_pkg::seq_state_t state_q, state_d;
  logic [7:0]  tbl_q [TL];
  logic [7:0]  tbl_d [TL];
  logic [TL-1:0] tbl_we;
  logic [15:0] ee_ptr_q, ee_ptr_d, src_q, src_d;
  logic [7:0]  ent_cnt_q, ent_cnt_d, ents_q, ents_d, remain_q, remain_d;
  logic [3:0]  idx_q, idx_d;
  logic [8:0]  copied_q, copied_d;
  logic        done_q, done_d, map_rd_q, map_rd_d;
  logic [15:0] map_addr_q, map_addr_d;
  logic        wr_en, wr_hit, rd_hit, idle, start;
  logic [15:0] wr_addr;
  logic [31:0] wr_data, rd_data;
  logic [3:0]  wr_strb;
  logic [11:0] wr_idx, rd_idx;
  logic        push_valid, push_ready, push_fire;
  logic [7:0]  push_byte;
  logic [23:0] fifo_out;

  // =====================================================================
  // bus front end and output buffer
  axil_reg_port u_port (
    .clk_i         (clk_i),
    .rst_b_i       (rst_b_i),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_en_o       (wr_en),
    .wr_addr_o     (wr_addr),
    .wr_data_o     (wr_data),
    .wr_strb_o     (wr_strb),
    .wr_hit_i      (wr_hit),
    .rd_data_i     (rd_data),
    .rd_hit_i      (rd_hit)
  );

  // fifo back-pressure stalls the walk, so a slow eeprom is safe
  seq_fifo #(.WIDTH(24), .DEPTH(8)) u_fifo (
    .clk_i       (clk_i),
    .rst_b_i     (rst_b_i),
    .in_valid_i  (push_valid),
    .in_ready_o  (push_ready),
    .in_data_i   ({ee_ptr_q, push_byte}),
    .out_valid_o (ee_valid_o),
    .out_ready_i (ee_ready_i),
    .out_data_o  (fifo_out)
  );
  assign ee_addr_o = fifo_out[23:8];
  assign ee_data_o = fifo_out[7:0];

  // =====================================================================
  // address decode; hits and start need upper address bits zero, table, pointer and count writes ignore them
  assign idle   = (state_q == store_seq_pkg::ST_IDLE);
  assign wr_idx = wr_addr[13:2];
  assign rd_idx = s_axi_araddr[13:2];

  always_comb begin
    rd_hit  = (s_axi_araddr[15:14] == 2'h0);
    rd_data = 32'h0000_0000;
    if (rd_idx == store_seq_pkg::IDX_CTRL) begin
      rd_data = 32'h0000_0000;
    end else if (rd_idx == store_seq_pkg::IDX_STATUS) begin
      rd_data[store_seq_pkg::STAT_BUSY_BIT] = !idle;
      rd_data[store_seq_pkg::STAT_DONE_BIT] = done_q;
    end else if (rd_idx == store_seq_pkg::IDX_EE_PTR) begin
      rd_data[15:0] = ee_ptr_q;
    end else if (rd_idx == store_seq_pkg::IDX_ENTRY_CNT) begin
      rd_data[7:0] = ent_cnt_q;
    end else if (rd_idx >= store_seq_pkg::IDX_LOOP2_INSTR &&
                 rd_idx <= store_seq_pkg::IDX_ANALOG3_LO) begin
      rd_data[7:0] = tbl_q[4'(rd_idx - store_seq_pkg::IDX_LOOP2_INSTR)];
    end else begin
      rd_hit = 1'b0;
    end
  end

  // writes while busy are answered but ignored, so the walk stays sane
  always_comb begin
    wr_hit = (wr_addr[15:14] == 2'h0) &&
             (wr_idx <= store_seq_pkg::IDX_ENTRY_CNT ||
              (wr_idx >= store_seq_pkg::IDX_LOOP2_INSTR &&
               wr_idx <= store_seq_pkg::IDX_ANALOG3_LO));
    start  = wr_en && wr_hit && wr_strb[0] && idle &&
             (wr_idx == store_seq_pkg::IDX_CTRL) &&
             wr_data[store_seq_pkg::CTRL_START_BIT];
  end

  // =====================================================================
  // sequence table, one byte register per entry byte
  for (genvar g = 0; g < TL; g++) begin : g_tbl
    assign tbl_we[g] = wr_en && wr_strb[0] && idle &&
      (wr_idx == store_seq_pkg::IDX_LOOP2_INSTR + 12'(g));
    assign tbl_d[g]  = tbl_we[g] ? wr_data[7:0] : tbl_q[g];
    always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        tbl_q[g] <= store_seq_pkg::TBL_RST[g];
      end else begin
        tbl_q[g] <= tbl_d[g];
      end
    end
  end

  // =====================================================================
  // store sequencer: one byte per push, pointer steps per byte
  always_comb begin
    state_d    = state_q;
    ee_ptr_d   = ee_ptr_q;
    ent_cnt_d  = ent_cnt_q;
    ents_d     = ents_q;
    idx_d      = idx_q;
    remain_d   = remain_q;
    src_d      = src_q;
    copied_d   = copied_q;
    done_d     = done_q;
    map_rd_d   = 1'b0;
    map_addr_d = map_addr_q;
    push_valid = 1'b0;
    push_byte  = 8'h00;
    if (idle && wr_en && wr_strb[0] && wr_idx == store_seq_pkg::IDX_EE_PTR)
    begin
      ee_ptr_d = wr_data[15:0];
    end
    if (idle && wr_en && wr_strb[0] &&
        wr_idx == store_seq_pkg::IDX_ENTRY_CNT) begin
      ent_cnt_d = wr_data[7:0];
    end
    case (state_q)
      store_seq_pkg::ST_IDLE: begin
        if (start && ent_cnt_q != 8'h00) begin
          idx_d   = 4'h0;
          ents_d  = (ent_cnt_q > store_seq_pkg::NUM_ENTRIES) ?
                    store_seq_pkg::NUM_ENTRIES : ent_cnt_q;
          done_d  = 1'b0;
          state_d = store_seq_pkg::ST_INSTR;
        end
      end
      store_seq_pkg::ST_INSTR: begin
        push_valid = 1'b1;
        push_byte  = tbl_q[idx_q];
        if (push_ready) begin
          remain_d = tbl_q[idx_q];
          copied_d = 9'h000;
          state_d  = store_seq_pkg::ST_ADDR_HI;
        end
      end
      store_seq_pkg::ST_ADDR_HI: begin
        push_valid = 1'b1;
        push_byte  = tbl_q[idx_q + 4'h1];
        if (push_ready) begin
          src_d[15:8] = tbl_q[idx_q + 4'h1];
          state_d     = store_seq_pkg::ST_ADDR_LO;
        end
      end
      store_seq_pkg::ST_ADDR_LO: begin
        push_valid = 1'b1;
        push_byte  = tbl_q[idx_q + 4'h2];
        if (push_ready) begin
          src_d      = {src_q[15:8], tbl_q[idx_q + 4'h2]};
          map_rd_d   = 1'b1;
          map_addr_d = {src_q[15:8], tbl_q[idx_q + 4'h2]};
          state_d    = store_seq_pkg::ST_READ;
        end
      end
      store_seq_pkg::ST_READ: begin
        state_d = store_seq_pkg::ST_COPY; // map data lands now
      end
      store_seq_pkg::ST_COPY: begin
        push_valid = 1'b1;
        push_byte  = map_data_i;
        if (push_ready) begin
          copied_d = copied_q + 9'h001;
          if (remain_q == 8'h00) begin
            if (ents_q == 8'h01) begin
              done_d  = 1'b1;
              state_d = store_seq_pkg::ST_IDLE;
            end else begin
              idx_d   = idx_q + store_seq_pkg::ENTRY_BYTES;
              ents_d  = ents_q - 8'h01;
              state_d = store_seq_pkg::ST_INSTR;
            end
          end else begin
            remain_d   = remain_q - 8'h01;
            src_d      = src_q + 16'h0001;
            map_rd_d   = 1'b1;
            map_addr_d = src_q + 16'h0001;
            state_d    = store_seq_pkg::ST_READ;
          end
        end
      end
      default: state_d = store_seq_pkg::ST_IDLE;
    endcase
    push_fire = push_valid && push_ready;
    if (push_fire) begin
      ee_ptr_d = ee_ptr_q + 16'h0001;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q    <= store_seq_pkg::ST_IDLE;
      ee_ptr_q   <= store_seq_pkg::RST_EE_PTR;
      ent_cnt_q  <= store_seq_pkg::RST_ENTRY_CNT;
      ents_q     <= 8'h00;
      idx_q      <= 4'h0;
      remain_q   <= 8'h00;
      src_q      <= 16'h0000;
      copied_q   <= 9'h000;
      done_q     <= 1'b0;
      map_rd_q   <= 1'b0;
      map_addr_q <= 16'h0000;
    end else begin
      state_q    <= state_d;
      ee_ptr_q   <= ee_ptr_d;
      ent_cnt_q  <= ent_cnt_d;
      ents_q     <= ents_d;
      idx_q      <= idx_d;
      remain_q   <= remain_d;
      src_q      <= src_d;
      copied_q   <= copied_d;
      done_q     <= done_d;
      map_rd_q   <= map_rd_d;
      map_addr_q <= map_addr_d;
    end
  end

  assign map_rd_o   = map_rd_q;
  assign map_addr_o = map_addr_q;

  // =====================================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  a_instr_first: assert property (
    state_q == store_seq_pkg::ST_INSTR && push_fire |->
      push_byte == tbl_q[idx_q] ##1 state_q == store_seq_pkg::ST_ADDR_HI)
    else $error("instruction byte not pushed first");
  a_ptr_step: assert property (
    push_fire |=> ee_ptr_q == $past(ee_ptr_q) + 16'h0001)
    else $error("eeprom pointer did not step by one");
  // back-to-back address pushes only; a stall in between shifts $past
  a_addr_pair: assert property (
    (state_q == store_seq_pkg::ST_ADDR_HI && push_fire) ##1
      (state_q == store_seq_pkg::ST_ADDR_LO && push_fire) |=>
      ee_ptr_q == $past(ee_ptr_q, 2) + 16'h0002)
    else $error("address bytes did not move pointer by two");
  a_src_load: assert property (
    state_q == store_seq_pkg::ST_ADDR_LO && push_fire |=>
      map_rd_q && map_addr_q == {tbl_q[idx_q + 4'h1], tbl_q[idx_q + 4'h2]})
    else $error("copy start address not taken from table");
  a_copy_count: assert property (
    state_q == store_seq_pkg::ST_COPY && push_fire && remain_q == 8'h00
      |-> copied_q + 9'h001 == {1'b0, tbl_q[idx_q]} + 9'h001)
    else $error("wrong number of map bytes copied");
  a_read_copy: assert property (
    map_rd_q |=> state_q == store_seq_pkg::ST_COPY &&
      push_byte == map_data_i && src_q == $past(map_addr_q))
    else $error("map read not followed by copy");
  a_next_entry: assert property (
    state_q == store_seq_pkg::ST_COPY && push_fire &&
      remain_q == 8'h00 && ents_q != 8'h01 |=>
      state_q == store_seq_pkg::ST_INSTR && idx_q == $past(idx_q) + 4'h3)
    else $error("next entry not fetched in order");
  a_table_reset: assert property (
    $rose(rst_b_i) |-> tbl_q[0] == 8'h33 && tbl_q[3] == 8'h1E &&
      tbl_q[6] == 8'h0E && {tbl_q[1], tbl_q[2]} == 16'h0640 &&
      {tbl_q[4], tbl_q[5]} == 16'h0700 && {tbl_q[7], tbl_q[8]} == 16'h0730)
    else $error("sequence table defaults wrong");

  c_start: cover property (start);
  c_done: cover property (!done_q ##1 done_q);
  c_stall: cover property (push_valid && !push_ready);
  c_second: cover property (state_q == store_seq_pkg::ST_INSTR &&
                            idx_q == 4'h3);
endmodule // eeprom_store_sequencer

// File: src/seq_fifo.sv
// fifo of WIDTH-bit words with a registered output stage
// assumes DEPTH is a power of two; holds DEPTH words plus the output one
module seq_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
  logic [AW:0]      count_q, count_d;
  logic             out_valid_q, out_valid_d;
  logic [WIDTH-1:0] out_data_q, out_data_d;
  logic             push, load;

  // =====================================================================
  // pointer and output stage next values
  always_comb begin
    in_ready_o  = (count_q != (AW+1)'(DEPTH));
    push        = in_valid_i && in_ready_o;
    load        = (count_q != '0) && (!out_valid_q || out_ready_i);
    wr_ptr_d    = push ? wr_ptr_q + 1'b1 : wr_ptr_q;
    rd_ptr_d    = load ? rd_ptr_q + 1'b1 : rd_ptr_q;
    count_d     = count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
    out_valid_d = load ? 1'b1 : (out_ready_i ? 1'b0 : out_valid_q);
    out_data_d  = load ? mem[rd_ptr_q] : out_data_q;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr_q    <= '0;
      rd_ptr_q    <= '0;
      count_q     <= '0;
      out_valid_q <= 1'b0;
      out_data_q  <= '0;
    end else begin
      wr_ptr_q    <= wr_ptr_d;
      rd_ptr_q    <= rd_ptr_d;
      count_q     <= count_d;
      out_valid_q <= out_valid_d;
      out_data_q  <= out_data_d;
    end
  end

  // storage needs no reset; count guards every read
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data_i;
    end
  end

  assign out_valid_o = out_valid_q;
  assign out_data_o  = out_data_q;
endmodule // seq_fifo

// File: src/store_seq_pkg.sv
// constants shared by the eeprom store sequencer and its helpers
// assumes one 250 MHz clock and an AXI4-Lite register port
package store_seq_pkg;

  // =====================================================================
  // register indices (byte address = index * 4)
  localparam logic [11:0] IDX_CTRL         = 12'h000;
  localparam logic [11:0] IDX_STATUS       = 12'h001;
  localparam logic [11:0] IDX_EE_PTR       = 12'h002;
  localparam logic [11:0] IDX_ENTRY_CNT    = 12'h003;
  localparam logic [11:0] IDX_LOOP2_INSTR  = 12'hE40;
  localparam logic [11:0] IDX_LOOP2_HI     = 12'hE41;
  localparam logic [11:0] IDX_LOOP2_LO     = 12'hE42;
  localparam logic [11:0] IDX_LOOP3_INSTR  = 12'hE43;
  localparam logic [11:0] IDX_LOOP3_HI     = 12'hE44;
  localparam logic [11:0] IDX_LOOP3_LO     = 12'hE45;
  localparam logic [11:0] IDX_ANALOG3_INSTR = 12'hE46;
  localparam logic [11:0] IDX_ANALOG3_HI   = 12'hE47;
  localparam logic [11:0] IDX_ANALOG3_LO   = 12'hE48;

  // =====================================================================
  // table shape and field positions
  localparam int TBL_LEN        = 9;
  localparam logic [3:0] ENTRY_BYTES = 4'h3;
  localparam logic [7:0] NUM_ENTRIES = 8'h03;
  localparam int CTRL_START_BIT = 0;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_DONE_BIT  = 1;

  // =====================================================================
  // reset values
  localparam logic [7:0] RST_LOOP2_INSTR   = 8'h33;
  localparam logic [7:0] RST_LOOP2_HI      = 8'h06;
  localparam logic [7:0] RST_LOOP2_LO      = 8'h40;
  localparam logic [7:0] RST_LOOP3_INSTR   = 8'h1E;
  localparam logic [7:0] RST_LOOP3_HI      = 8'h07;
  localparam logic [7:0] RST_LOOP3_LO      = 8'h00;
  localparam logic [7:0] RST_ANALOG3_INSTR = 8'h0E;
  localparam logic [7:0] RST_ANALOG3_HI    = 8'h07;
  localparam logic [7:0] RST_ANALOG3_LO    = 8'h30;
  localparam logic [7:0] TBL_RST [TBL_LEN] = '{
    RST_LOOP2_INSTR, RST_LOOP2_HI, RST_LOOP2_LO,
    RST_LOOP3_INSTR, RST_LOOP3_HI, RST_LOOP3_LO,
    RST_ANALOG3_INSTR, RST_ANALOG3_HI, RST_ANALOG3_LO};
  localparam logic [15:0] RST_EE_PTR    = 16'h0000;
  localparam logic [7:0]  RST_ENTRY_CNT = 8'h03;

  // =====================================================================
  // bus answers and sequencer states
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [5:0] {
    ST_IDLE    = 6'h01,
    ST_INSTR   = 6'h02,
    ST_ADDR_HI = 6'h04,
    ST_ADDR_LO = 6'h08,
    ST_READ    = 6'h10,
    ST_COPY    = 6'h20
  } seq_state_t;

endpackage

// File: testbench/ee_far_side.sv
// far side of the sequencer: register map read port and eeprom write port
// assumes map data is wanted one cycle after the read pulse
module ee_far_side (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        hold_i,
  input  wire logic        map_rd_i,
  input  wire logic [15:0] map_addr_i,
  output logic [7:0]       map_data_o,
  output logic             ee_ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // =====================================================================
  // map byte is a pattern of its address, held until the next read
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i)
      map_data_o <= 8'hA5;
    else if (map_rd_i)
      map_data_o <= map_addr_i[7:0] ^ map_addr_i[15:8] ^ 8'h5A;
  end
  // eeprom stalls at random, or fully while held, to back up the fifo
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i)
      ee_ready_o <= 1'b0;
    else
      ee_ready_o <= !hold_i && ($urandom % 4 != 0);
  end
endmodule // ee_far_side

// File: testbench/eeprom_store_sequencer_bench.sv
// bench for the store sequencer: register port, table and byte stream
// assumes ee_far_side as the map and eeprom model
module eeprom_store_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // =====================================================================
  // signals; bready and rready stay high, the master never stalls
  logic        clk_i = 0, rst_b_i = 0, hold = 1, bready = 1, rready = 1;
  logic        awvalid = 0, wvalid = 0, arvalid = 0;
  logic        awready, wready, bvalid, arready, rvalid, map_rd, ee_valid;
  logic        ee_ready;
  logic [3:0]  strb = 4'hF;
  logic [15:0] awaddr = 0, araddr = 0, map_addr, ee_addr;
  logic [31:0] wdata = 0, rdata;
  logic [1:0]  bresp, rresp;
  logic [7:0]  map_data, ee_data;
  logic [7:0]  tb [9] = '{8'h33, 8'h06, 8'h40, 8'h1E, 8'h07, 8'h00,
                          8'h0E, 8'h07, 8'h30};
  logic [39:0] eq [$], rq [$];
  int          mismatches = 0, n_compared = 0;

  initial forever #2 clk_i = ~clk_i;

  eeprom_store_sequencer u_eeprom_store_sequencer (.clk_i(clk_i),
    .rst_b_i(rst_b_i), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .map_rd_o(map_rd), .map_addr_o(map_addr), .map_data_i(map_data),
    .ee_valid_o(ee_valid), .ee_addr_o(ee_addr), .ee_data_o(ee_data),
    .ee_ready_i(ee_ready));
  ee_far_side u_ee_far_side (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .hold_i(hold), .map_rd_i(map_rd), .map_addr_i(map_addr),
    .map_data_o(map_data), .ee_ready_o(ee_ready));

  // =====================================================================
  // comparison, verdict and bounded waits
  task automatic chk(input logic [39:0] s, input logic [39:0] e);
    n_compared++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic complete_run();
    $display("mismatches=%0d compared=%0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic wait_hi(ref logic s);
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (s !== 1'b1 && n < 9000);
    if (n >= 9000) begin
      mismatches++;
      complete_run();
    end
  endtask
  // =====================================================================
  // bus cycles; aw and w may be taken at different edges
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic pa, pw;
    pa = 1;
    pw = 1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    for (int n = 0; n < 100 && (pa || pw); n++) begin
      @(posedge clk_i);
      if (pa && awready) begin
        pa = 0;
        awvalid <= 0;
      end
      if (pw && wready) begin
        pw = 0;
        wvalid <= 0;
      end
    end
    // a write that is never taken is a hang, not a pass
    if (pa || pw) begin
      mismatches++;
      complete_run();
    end
    wait_hi(bvalid);
    chk({38'h0, bresp}, {38'h0, (a[15:4] == 12'h010) ? 2'h2 : 2'h0});
  endtask
  task automatic rd(input logic [15:0] a, input logic [33:0] e);
    rq.push_back({6'h0, e});
    araddr <= a;
    arvalid <= 1;
    wait_hi(arready);
    arvalid <= 0;
    wait_hi(rvalid);
  endtask
  // one walk: note every expected eeprom byte, start, stall, then drain
  task automatic run(input logic [15:0] p, input logic [7:0] c);
    logic [15:0] s;
    wr(16'h0008, {16'h0, p});
    wr(16'h000C, {24'h0, c});
    for (int e = 0; e < ((c > 3) ? 3 : c); e++) begin
      s = {tb[3*e+1], tb[3*e+2]};
      for (int k = 0; k < 3; k++)
        eq.push_back({16'h0, p + 16'(k), tb[3*e+k]});
      p = p + 16'h3;
      for (int k = 0; k <= tb[3*e]; k++) begin
        eq.push_back({16'h0, p, s[7:0] ^ s[15:8] ^ 8'h5A});
        s++;
        p++;
      end
    end
    hold <= 1;
    wr(16'h0000, 32'h1);
    repeat (40) @(posedge clk_i);
    hold <= 0;
    for (int n = 0; eq.size() > 0; n++) begin
      @(posedge clk_i);
      if (n > 9000) begin
        mismatches++;
        complete_run();
      end
    end
    rd(16'h0004, 34'h2);
    rd(16'h0008, {18'h0, p});
  endtask

  // watcher: oldest note against each result as it appears
  always @(posedge clk_i) begin
    if (ee_valid && ee_ready)
      chk({16'h0, ee_addr, ee_data}, eq.pop_front());
    if (rvalid && rready)
      chk({6'h0, rresp, rdata}, rq.pop_front());
  end

  // =====================================================================
  // main sequence: defaults, unmapped place, default walk, random entry
  initial begin
    void'($urandom(92));
    repeat (20) @(posedge clk_i);
    rst_b_i <= 1;
    repeat (2) @(posedge clk_i);
    for (int i = 0; i < 9; i++)
      rd(16'h3900 + 16'(4 * i), {26'h0, tb[i]});
    rd(16'h0100, {2'h2, 32'h0});
    wr(16'h0100, 32'h1);
    // low strobe bit must leave the table alone
    strb <= 4'h0;
    wr(16'h3900, 32'h55);
    strb <= 4'hF;
    rd(16'h3900, {26'h0, tb[0]});
    // zero entries: start is ignored, status stays clear
    wr(16'h000C, 32'h0);
    wr(16'h0000, 32'h1);
    rd(16'h0004, 34'h0);
    run(16'h0010, 8'h07);
    for (int i = 0; i < 3; i++) begin
      tb[i] = 8'($urandom);
      wr(16'h3900 + 16'(4 * i), {24'h0, tb[i]});
    end
    run(16'($urandom), 8'h01);
    // let the watcher take the last read, then every note must be used
    repeat (2) @(posedge clk_i);
    chk(40'(rq.size() + eq.size()), 40'h0);
    complete_run();
  end
endmodule // eeprom_store_sequencer_bench
